// [src/sfq_dev.sv]
/*
  Flash command sequencer: decodes serial commands from the link, keeps
  the write latch, auto-increment state and protect bits, and hands each
  accepted program or erase to the array logic as a one-cycle operation.
  Assumes the array logic reports its self-timed work on busy_i, and that
  the link pins are asynchronous to clk_i.
*/
`timescale 1ns/10ps
`default_nettype none
`include "sfq_map.svh"
module sfq_dev (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Serial link.
  sfq_link_if.dev link,
  // Array side.
  input wire logic busy_i,
  output logic op_valid_o,
  output sfq_pkg::sfq_op_t op_kind_o,
  output logic [17:0] op_addr_o,
  output logic [7:0] op_data_o,
  output logic [7:0] status_o
);
  import sfq_pkg::*;

  typedef struct packed {
    logic [2:0] cs_s;
    logic [2:0] sck_s;
    logic [1:0] mosi_s;
    logic [1:0] wp_s;
    logic [2:0] bit_cnt;
    logic [2:0] byte_cnt;
    logic [7:0] in_sr;
    logic [7:0] opcode;
    logic [23:0] addr;
    logic [7:0] data;
    logic [7:0] out_sr;
    logic out_on;
    logic id_sel;
    logic miso;
    logic miso_oe;
    logic write_latch_bit;
    logic auto_increment_program;
    logic arm;
    logic protect_lock_bit;
    logic [1:0] bp;
    logic [17:0] aai_addr;
    logic op_valid;
    sfq_op_t op_kind;
    logic [17:0] op_addr;
    logic [7:0] op_data;
    logic [7:0] status;
  } sfq_dev_st_t;

  sfq_dev_st_t st_r;
  sfq_dev_st_t st_nxt;

  function automatic logic [18:0] sfq_prot_base(input logic [1:0] lvl);
    case (lvl)
      2'h0: sfq_prot_base = `SFQ_PROT_BASE_0;
      2'h1: sfq_prot_base = `SFQ_PROT_BASE_1;
      2'h2: sfq_prot_base = `SFQ_PROT_BASE_2;
      default: sfq_prot_base = `SFQ_PROT_BASE_3;
    endcase
  endfunction

  logic sel;
  logic sck_rise;
  logic sck_fall;
  logic cs_rise;
  logic wp_low;
  logic [7:0] shift_in;
  logic short_form;
  logic [18:0] base;
  logic [18:0] cmd_addr;
  logic [18:0] sect_addr;
  logic [18:0] blk_addr;
  logic [7:0] stat_now;

  always_comb begin
    sel = ~st_r.cs_s[1];
    sck_rise = st_r.sck_s[1] & ~st_r.sck_s[2];
    sck_fall = ~st_r.sck_s[1] & st_r.sck_s[2];
    cs_rise = st_r.cs_s[1] & ~st_r.cs_s[2];
    wp_low = ~st_r.wp_s[1];
    shift_in = {st_r.in_sr[6:0], st_r.mosi_s[1]};
    short_form = (st_r.opcode == `SFQ_OP_STAT_WRITE) ||
                 ((st_r.opcode == `SFQ_OP_PROG_AUTO) && st_r.auto_increment_program);
    base = sfq_prot_base(st_r.bp);
    cmd_addr = {1'b0, st_r.addr[17:0]};
    sect_addr = {1'b0, st_r.addr[17:12], 12'h000};
    blk_addr = {1'b0, st_r.addr[17:15], 15'h0000};
    stat_now = 8'h00;
    stat_now[`SFQ_ST_BUSY] = busy_i;
    stat_now[`SFQ_ST_LATCH] = st_r.write_latch_bit;
    stat_now[`SFQ_ST_LVL_LO] = st_r.bp[0];
    stat_now[`SFQ_ST_LVL_HI] = st_r.bp[1];
    stat_now[`SFQ_ST_AUTO] = st_r.auto_increment_program;
    stat_now[`SFQ_ST_LOCK] = st_r.protect_lock_bit;
  end

  always_comb begin
    st_nxt = st_r;
    st_nxt.cs_s = {st_r.cs_s[1:0], link.cs_n};
    st_nxt.sck_s = {st_r.sck_s[1:0], link.sck};
    st_nxt.mosi_s = {st_r.mosi_s[0], link.mosi};
    st_nxt.wp_s = {st_r.wp_s[0], link.wp_n};
    st_nxt.op_valid = 1'b0;
    st_nxt.status = stat_now;

    if (!sel) begin
      st_nxt.bit_cnt = 3'h0;
      st_nxt.byte_cnt = 3'h0;
      st_nxt.out_on = 1'b0;
      st_nxt.miso_oe = 1'b0;
    end else if (sck_rise) begin
      st_nxt.in_sr = shift_in;
      st_nxt.bit_cnt = st_r.bit_cnt + 3'h1;
      if (st_r.bit_cnt == 3'h7) begin
        if (st_r.byte_cnt != 3'h7) begin
          st_nxt.byte_cnt = st_r.byte_cnt + 3'h1;
        end
        case (st_r.byte_cnt)
          3'h0: st_nxt.opcode = shift_in;
          3'h1: st_nxt.addr[23:16] = shift_in;
          3'h2: st_nxt.addr[15:8] = shift_in;
          3'h3: st_nxt.addr[7:0] = shift_in;
          default: st_nxt.addr = st_r.addr;
        endcase
        if ((short_form && st_r.byte_cnt == 3'h1) ||
            (!short_form && st_r.byte_cnt == 3'h4)) begin
          st_nxt.data = shift_in;
        end
        if ((st_r.byte_cnt == 3'h0 && shift_in == `SFQ_OP_STAT_READ) ||
            (st_r.byte_cnt != 3'h0 && st_r.opcode == `SFQ_OP_STAT_READ))
        begin
          st_nxt.out_sr = stat_now;
          st_nxt.out_on = 1'b1;
        end
        if (st_r.opcode == `SFQ_OP_ID_A || st_r.opcode == `SFQ_OP_ID_B)
        begin
          if (st_r.byte_cnt == 3'h3) begin
            st_nxt.out_sr = shift_in[0] ? `SFQ_DEV_ID : `SFQ_MFR_ID;
            st_nxt.id_sel = ~shift_in[0];
            st_nxt.out_on = 1'b1;
          end else if (st_r.byte_cnt > 3'h3) begin
            st_nxt.out_sr = st_r.id_sel ? `SFQ_DEV_ID : `SFQ_MFR_ID;
            st_nxt.id_sel = ~st_r.id_sel;
          end
        end
      end
    end else if (sck_fall && st_r.out_on) begin
      st_nxt.miso = st_r.out_sr[7];
      st_nxt.out_sr = {st_r.out_sr[6:0], 1'b0};
      st_nxt.miso_oe = 1'b1;
    end

    // Only whole-byte frames commit; a frame cut mid-byte is dropped.
    if (cs_rise && st_r.bit_cnt == 3'h0 && st_r.byte_cnt != 3'h0) begin
      st_nxt.arm = 1'b0;
      case (st_r.opcode)
        `SFQ_OP_LATCH_SET: begin
          if (st_r.byte_cnt == 3'h1) begin
            st_nxt.write_latch_bit = 1'b1;
          end
        end
        `SFQ_OP_LATCH_CLR: begin
          if (st_r.byte_cnt == 3'h1) begin
            st_nxt.write_latch_bit = 1'b0;
            st_nxt.auto_increment_program = 1'b0;
          end
        end
        `SFQ_OP_STAT_ARM: begin
          if (st_r.byte_cnt == 3'h1) begin
            st_nxt.arm = 1'b1;
          end
        end
        `SFQ_OP_STAT_WRITE: begin
          if (st_r.byte_cnt == 3'h2 && st_r.arm &&
              !(wp_low && st_r.protect_lock_bit)) begin
            st_nxt.bp = {st_r.data[`SFQ_ST_LVL_HI],
                         st_r.data[`SFQ_ST_LVL_LO]};
            st_nxt.protect_lock_bit = st_r.data[`SFQ_ST_LOCK];
          end
        end
        `SFQ_OP_SECT_ERASE: begin
          if (st_r.byte_cnt == 3'h4 && st_r.write_latch_bit && !st_r.auto_increment_program &&
              sect_addr < base) begin
            st_nxt.op_valid = 1'b1;
            st_nxt.op_kind = SFQ_OP_SECT;
            st_nxt.op_addr = sect_addr[17:0];
            st_nxt.op_data = 8'hff;
            st_nxt.write_latch_bit = 1'b0;
          end
        end
        `SFQ_OP_BLK_ERASE: begin
          if (st_r.byte_cnt == 3'h4 && st_r.write_latch_bit && !st_r.auto_increment_program &&
              blk_addr < base) begin
            st_nxt.op_valid = 1'b1;
            st_nxt.op_kind = SFQ_OP_BLK;
            st_nxt.op_addr = blk_addr[17:0];
            st_nxt.op_data = 8'hff;
            st_nxt.write_latch_bit = 1'b0;
          end
        end
        `SFQ_OP_CHIP_ERASE: begin
          if (st_r.byte_cnt == 3'h1 && st_r.write_latch_bit && !st_r.auto_increment_program &&
              st_r.bp == 2'h0) begin
            st_nxt.op_valid = 1'b1;
            st_nxt.op_kind = SFQ_OP_CHIP;
            st_nxt.op_addr = 18'h00000;
            st_nxt.op_data = 8'hff;
            st_nxt.write_latch_bit = 1'b0;
          end
        end
        `SFQ_OP_PROG_AUTO: begin
          if (!st_r.auto_increment_program && st_r.byte_cnt == 3'h5 && st_r.write_latch_bit &&
              cmd_addr < base) begin
            st_nxt.op_valid = 1'b1;
            st_nxt.op_kind = SFQ_OP_PROG;
            st_nxt.op_addr = cmd_addr[17:0];
            st_nxt.op_data = st_r.data;
            if (cmd_addr + 19'h1 >= base) begin
              st_nxt.write_latch_bit = 1'b0;
            end else begin
              st_nxt.auto_increment_program = 1'b1;
              st_nxt.aai_addr = st_r.addr[17:0] + 18'h1;
            end
          end else if (st_r.auto_increment_program && st_r.byte_cnt == 3'h2 &&
                       {1'b0, st_r.aai_addr} < base) begin
            st_nxt.op_valid = 1'b1;
            st_nxt.op_kind = SFQ_OP_PROG;
            st_nxt.op_addr = st_r.aai_addr;
            st_nxt.op_data = st_r.data;
            st_nxt.aai_addr = st_r.aai_addr + 18'h1;
            if ({1'b0, st_r.aai_addr} + 19'h1 >= base) begin
              st_nxt.auto_increment_program = 1'b0;
              st_nxt.write_latch_bit = 1'b0;
            end
          end
        end
        default: st_nxt.arm = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= '0;
      st_r.cs_s <= 3'h7;
      st_r.wp_s <= 2'h3;
      st_r.op_kind <= SFQ_OP_PROG;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign link.miso = st_r.miso;
  assign link.miso_oe = st_r.miso_oe;
  assign op_valid_o = st_r.op_valid;
  assign op_kind_o = st_r.op_kind;
  assign op_addr_o = st_r.op_addr;
  assign op_data_o = st_r.op_data;
  assign status_o = st_r.status;
endmodule
`default_nettype wire

// [src/sfq_host.sv]
/*
  Host controller: software writes a command word over classic Wishbone,
  and the controller runs one framed serial transfer on the link.
  Assumes a Wishbone master on clk_i and the device at the link's far end.
*/
`timescale 1ns/10ps
`default_nettype none
`include "sfq_map.svh"
module sfq_host (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave.
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [4:2] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Serial link.
  sfq_link_if.host link
);
  import sfq_pkg::*;

  typedef struct packed {
    sfq_hstate_t state;
    logic [3:0] cnt;
    logic [2:0] bitn;
    logic [3:0] byten;
    logic [7:0] tx_sr;
    logic [7:0] rx_sr;
    logic [7:0] rx_last;
    logic [14:0] cmd;
    logic [23:0] addr;
    logic [7:0] wdata;
    logic wp_n;
    logic cs_n;
    logic sck;
    logic mosi;
    logic [1:0] miso_s;
    logic ack;
    logic [31:0] dat;
  } sfq_host_st_t;

  localparam logic [3:0] HALF_LAST = 4'(`SFQ_HALF_CYC - 1);

  sfq_host_st_t st_r;
  sfq_host_st_t st_nxt;

  function automatic logic [7:0] sfq_tx_byte(input sfq_host_st_t s,
                                             input logic [3:0] k);
    if (k >= {1'b0, s.cmd[10:8]}) begin
      sfq_tx_byte = 8'h00;
    end else if (k == 4'h0) begin
      sfq_tx_byte = s.cmd[7:0];
    end else if (s.cmd[14] || k > 4'h3) begin
      sfq_tx_byte = s.wdata;
    end else if (k == 4'h1) begin
      sfq_tx_byte = s.addr[23:16];
    end else if (k == 4'h2) begin
      sfq_tx_byte = s.addr[15:8];
    end else begin
      sfq_tx_byte = s.addr[7:0];
    end
  endfunction

  logic wr;
  logic half_end;
  logic [7:0] rx_byte;
  logic [7:0] next_tx;
  logic [3:0] total;

  always_comb begin
    // A write lands at the edge where the master sees ack high.
    wr = cyc_i & stb_i & we_i & st_r.ack & sel_i[0];
    half_end = st_r.cnt == HALF_LAST;
    rx_byte = {st_r.rx_sr[6:0], st_r.miso_s[1]};
    next_tx = sfq_tx_byte(st_r, st_r.byten + 4'h1);
    total = {1'b0, st_r.cmd[10:8]} + {1'b0, st_r.cmd[13:11]};

    st_nxt = st_r;
    st_nxt.miso_s = {st_r.miso_s[0], link.miso_line};
    st_nxt.ack = cyc_i & stb_i & ~st_r.ack;
    st_nxt.cnt = half_end ? 4'h0 : st_r.cnt + 4'h1;
    case (adr_i)
      `SFQ_REG_CMD: st_nxt.dat = {17'h0, st_r.cmd};
      `SFQ_REG_ADDR: st_nxt.dat = {8'h0, st_r.addr};
      `SFQ_REG_WDATA: st_nxt.dat = {24'h0, st_r.wdata};
      `SFQ_REG_STAT: st_nxt.dat = {23'h0, st_r.rx_last,
                                   st_r.state != SFQ_H_IDLE};
      `SFQ_REG_WP: st_nxt.dat = {31'h0, st_r.wp_n};
      default: st_nxt.dat = 32'h0;
    endcase
    if (wr && st_r.state == SFQ_H_IDLE) begin
      case (adr_i)
        `SFQ_REG_ADDR: st_nxt.addr = dat_i[23:0];
        `SFQ_REG_WDATA: st_nxt.wdata = dat_i[7:0];
        `SFQ_REG_WP: st_nxt.wp_n = dat_i[0];
        default: st_nxt.wp_n = st_r.wp_n;
      endcase
    end

    case (st_r.state)
      SFQ_H_IDLE: begin
        st_nxt.cnt = 4'h0;
        if (wr && adr_i == `SFQ_REG_CMD && dat_i[10:8] != 3'h0) begin
          st_nxt.cmd = dat_i[14:0];
          st_nxt.state = SFQ_H_SETUP;
          st_nxt.cs_n = 1'b0;
          st_nxt.tx_sr = dat_i[7:0];
          st_nxt.mosi = dat_i[7];
          st_nxt.bitn = 3'h0;
          st_nxt.byten = 4'h0;
        end
      end
      SFQ_H_SETUP: begin
        if (half_end) begin
          st_nxt.sck = 1'b1;
          st_nxt.state = SFQ_H_SHIFT;
        end
      end
      SFQ_H_SHIFT: begin
        if (half_end && !st_r.sck) begin
          st_nxt.sck = 1'b1;
        end else if (half_end) begin
          st_nxt.sck = 1'b0;
          st_nxt.rx_sr = rx_byte;
          st_nxt.bitn = st_r.bitn + 3'h1;
          if (st_r.bitn == 3'h7) begin
            st_nxt.byten = st_r.byten + 4'h1;
            if (st_r.byten >= {1'b0, st_r.cmd[10:8]}) begin
              st_nxt.rx_last = rx_byte;
            end
            if (st_r.byten + 4'h1 == total) begin
              st_nxt.state = SFQ_H_HOLD;
            end else begin
              st_nxt.tx_sr = next_tx;
              st_nxt.mosi = next_tx[7];
            end
          end else begin
            st_nxt.tx_sr = {st_r.tx_sr[6:0], 1'b0};
            st_nxt.mosi = st_r.tx_sr[6];
          end
        end
      end
      SFQ_H_HOLD: begin
        if (half_end) begin
          st_nxt.cs_n = 1'b1;
          st_nxt.state = SFQ_H_GAP;
        end
      end
      SFQ_H_GAP: begin
        if (half_end) begin
          st_nxt.state = SFQ_H_IDLE;
        end
      end
      default: st_nxt.state = SFQ_H_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= '0;
      st_r.state <= SFQ_H_IDLE;
      st_r.cs_n <= 1'b1;
      st_r.wp_n <= 1'b1;
      st_r.miso_s <= 2'h3;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign dat_o = st_r.dat;
  assign ack_o = st_r.ack;
  assign link.cs_n = st_r.cs_n;
  assign link.sck = st_r.sck;
  assign link.mosi = st_r.mosi;
  assign link.wp_n = st_r.wp_n;
endmodule
`default_nettype wire

// [src/sfq_link_if.sv]
/*
  Serial link between the host controller and the flash sequencer.
  Assumes the data-out line has a pull-up when the device does not drive it.
*/
`timescale 1ns/10ps
`default_nettype none
interface sfq_link_if;
  logic cs_n;
  logic sck;
  logic mosi;
  logic wp_n;
  logic miso;
  logic miso_oe;
  logic miso_line;

  // Resolved level of the data-out wire.
  assign miso_line = miso_oe ? miso : 1'b1;

  modport dev (input cs_n, input sck, input mosi, input wp_n,
               output miso, output miso_oe);
  modport host (output cs_n, output sck, output mosi, output wp_n,
                input miso_line);
endinterface
`default_nettype wire

// [src/sfq_map.svh]
/*
  Constants for the serial flash command sequencer and its host controller.
  Assumes inclusion by bare name from the package and both end modules.
*/
// Summary of operation
// - Auto-increment: AFH, 24-bit address, one byte.
// - Further auto-increment bytes: AFH then data only.
// - Auto-increment into protected region is ignored.
// - 04H ends auto-increment, clears write latch.
// - No wrap; top unprotected address ends auto-increment.
// - Host polls busy before next byte.
// - Commands commit on chip-select rising edge.
// - 20H erases 4 KByte sector, bits 17..12.
// - 52H erases 32 KByte block, bits 17..15.
// - Protected sector or block erase is ignored.
// - 60H chip erase ignored if any protection.
// - Host sends write enable before program/erase.
// - Write enable sets the write latch.
// - Status readable at any time, even busy.
// - Status read repeats until chip select rises.
// - Status write arm lasts one command only.
// - Status write changes protect and lock bits.
// - Locked status write ignored while protect pin low.
// - Pin low: lock bit only sets, never clears.
// - Unlocked status write sets lock and levels together.
// - 90H/ABH read identity, address picks code.
// - Identity output alternates until chip select rises.
// - Every field is eight serial clock periods.
`ifndef SFQ_MAP_SVH
`define SFQ_MAP_SVH

`define SFQ_OP_PROG_AUTO 8'haf
`define SFQ_OP_SECT_ERASE 8'h20
`define SFQ_OP_BLK_ERASE 8'h52
`define SFQ_OP_CHIP_ERASE 8'h60
`define SFQ_OP_STAT_READ 8'h05
`define SFQ_OP_STAT_ARM 8'h50
`define SFQ_OP_STAT_WRITE 8'h01
`define SFQ_OP_LATCH_SET 8'h06
`define SFQ_OP_LATCH_CLR 8'h04
`define SFQ_OP_ID_A 8'h90
`define SFQ_OP_ID_B 8'hab

// Identity codes; the values are arbitrary.
`define SFQ_MFR_ID 8'h5a
`define SFQ_DEV_ID 8'ha5

`define SFQ_ADDR_W 18
`define SFQ_ARRAY_END 19'h40000
// First protected address for protect levels 0..3.
`define SFQ_PROT_BASE_0 19'h40000
`define SFQ_PROT_BASE_1 19'h30000
`define SFQ_PROT_BASE_2 19'h20000
`define SFQ_PROT_BASE_3 19'h00000

// Status byte bit positions.
`define SFQ_ST_BUSY 0
`define SFQ_ST_LATCH 1
`define SFQ_ST_LVL_LO 2
`define SFQ_ST_LVL_HI 3
`define SFQ_ST_AUTO 6
`define SFQ_ST_LOCK 7

// Host Wishbone word indices (byte address is four times these).
`define SFQ_REG_CMD 3'h0
`define SFQ_REG_ADDR 3'h1
`define SFQ_REG_WDATA 3'h2
`define SFQ_REG_STAT 3'h3
`define SFQ_REG_WP 3'h4

// Host serial clock timing.
`define SFQ_CLK_NS 25
`define SFQ_SCK_HALF_NS 200
`define SFQ_HALF_CYC ((`SFQ_SCK_HALF_NS + `SFQ_CLK_NS - 1) / `SFQ_CLK_NS)

`endif

// [src/sfq_pkg.sv]
/*
  Types shared by the flash command sequencer and its host controller.
  Assumes sfq_map.svh is on the include path.
*/
`include "sfq_map.svh"
package sfq_pkg;
  typedef enum logic [3:0] {
    SFQ_OP_PROG = 4'h1,
    SFQ_OP_SECT = 4'h2,
    SFQ_OP_BLK = 4'h4,
    SFQ_OP_CHIP = 4'h8
  } sfq_op_t;

  typedef enum logic [4:0] {
    SFQ_H_IDLE = 5'h01,
    SFQ_H_SETUP = 5'h02,
    SFQ_H_SHIFT = 5'h04,
    SFQ_H_HOLD = 5'h08,
    SFQ_H_GAP = 5'h10
  } sfq_hstate_t;
endpackage

// [verification/sfq_link_monitor.sv]
/*
  Concurrent checks on the serial link between host and flash sequencer.
  Assumes it is instantiated beside the link interface and sees clk_i.
*/
`timescale 1ns/10ps
`default_nettype none
module sfq_link_monitor (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Link signals.
  input wire logic cs_n,
  input wire logic sck,
  input wire logic mosi,
  input wire logic wp_n,
  input wire logic miso_oe
);
  logic [7:0] rise_r;
  logic sck_r;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Counts serial clock rises within the current frame.
  always_ff @(posedge clk_i) begin
    sck_r <= sck;
    if (rst_i || cs_n) begin
      rise_r <= 8'h00;
    end else if (sck && !sck_r) begin
      rise_r <= rise_r + 8'h01;
    end
  end

  sck_idle_a: assert property (cs_n |-> !sck)
    else $error("serial clock active outside a frame");
  sck_high_a: assert property ($rose(sck) |=> sck [*7] ##1 !sck)
    else $error("serial clock high phase not eight cycles");
  cs_setup_a: assert property ($fell(cs_n) |-> !sck [*8])
    else $error("serial clock rose too soon after select");
  cs_gap_a: assert property ($rose(cs_n) |-> cs_n [*8])
    else $error("deselect gap shorter than eight cycles");
  mosi_hold_a: assert property (sck |-> $stable(mosi))
    else $error("host data moved while clock high");
  whole_byte_a: assert property ($rose(cs_n) |->
    rise_r[2:0] == 3'h0 && rise_r != 8'h00)
    else $error("frame ended on a partial byte");
  miso_free_a: assert property ($rose(cs_n) |-> ##[0:6] !miso_oe)
    else $error("device still drives data after deselect");
  wp_steady_a: assert property (!cs_n && !$fell(cs_n) |-> $stable(wp_n))
    else $error("protect pin moved inside a frame");
endmodule
`default_nettype wire

// [verification/testbench.sv]
/*
  Testbench: drives the host over Wishbone, lets it talk to the sequencer
  across the link, and checks status bytes and array operations.
  Assumes both ends and the link interface are compiled before it.
*/
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import sfq_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic busy = 1'b0;
  logic [2:0] adr = 3'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic [31:0] rd;
  logic ack;
  logic op_valid;
  sfq_op_t op_kind;
  sfq_op_t seen_kind;
  logic [17:0] op_addr;
  logic [17:0] seen_addr;
  logic [7:0] op_data;
  logic [7:0] seen_data;
  logic [7:0] status;
  logic [7:0] r;
  int fails = 0;
  int n_compared = 0;
  int n_ops = 0;

  always #12.5 clk_i = ~clk_i;

  sfq_link_if link();
  sfq_host i_sfq_host (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc),
    .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'hf), .dat_i(wdat),
    .dat_o(rdat), .ack_o(ack), .link(link));
  sfq_dev i_sfq_dev (.clk_i(clk_i), .rst_i(rst_i), .link(link),
    .busy_i(busy), .op_valid_o(op_valid), .op_kind_o(op_kind),
    .op_addr_o(op_addr), .op_data_o(op_data), .status_o(status));
  sfq_link_monitor i_sfq_link_monitor (.clk_i(clk_i), .rst_i(rst_i),
    .cs_n(link.cs_n), .sck(link.sck), .mosi(link.mosi), .wp_n(link.wp_n),
    .miso_oe(link.miso_oe));

  // Records each operation handed to the array.
  always @(posedge clk_i) begin
    if (op_valid === 1'b1) begin
      n_ops++;
      seen_kind = op_kind;
      seen_addr = op_addr;
      seen_data = op_data;
    end
  end

  task print_verdict;
    $display("Compared %0d, failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task wb(input logic [2:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 64);
    rd = rdat;
    if (n >= 64) begin
      fails++;
      $display("Error %0t: no bus answer", $time);
    end
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  // Runs one framed transfer and waits for the controller to go idle.
  task cmd(input logic [7:0] op, input logic [2:0] tx, input logic [2:0] rx,
           input logic na, input logic [23:0] a, input logic [7:0] d);
    int n;
    n = 0;
    wb(3'h1, 1'b1, {8'h00, a});
    wb(3'h2, 1'b1, {24'h0, d});
    wb(3'h0, 1'b1, {17'h0, na, rx, tx, op});
    do begin
      wb(3'h3, 1'b0, 32'h0);
      n++;
    end while (rd[0] !== 1'b0 && n < 2000);
    if (n >= 2000) begin
      fails++;
      $display("Error %0t: controller stuck busy", $time);
    end
    r = rd[8:1];
  endtask

  task one(input logic [7:0] op);
    cmd(op, 3'h1, 3'h0, 1'b1, 24'h0, 8'h00);
  endtask

  task st;
    cmd(8'h05, 3'h1, 3'h1, 1'b1, 24'h0, 8'h00);
  endtask

  task status_write_cmd(input logic [7:0] d);
    one(8'h50);
    cmd(8'h01, 3'h2, 3'h0, 1'b1, 24'h0, d);
  endtask

  task er(input logic [7:0] op, input logic [23:0] a);
    one(8'h06);
    cmd(op, 3'h4, 3'h0, 1'b0, a, 8'h00);
  endtask

  task cmp8(input logic [7:0] g, input logic [7:0] e);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("Error %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // Expects exactly one new operation; an all-unknown address is not checked.
  task chk_op(input sfq_op_t k, input logic [17:0] a, input logic [7:0] d);
    n_compared++;
    if (n_ops !== 1 || seen_kind !== k || seen_data !== d ||
        (a !== 18'hx && seen_addr !== a)) begin
      fails++;
      $display("Error %0t: wrong array operation", $time);
    end
    n_ops = 0;
  endtask

  task chk_none;
    cmp8(8'(n_ops), 8'h00);
    n_ops = 0;
  endtask

  initial begin
    #(25 * 60000);
    fails++;
    $display("Error %0t: run timed out", $time);
    print_verdict;
  end

  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    wb(3'h5, 1'b0, 32'h0);
    cmp8(rd[7:0], 8'h00);
    st();
    cmp8(r, 8'h00);
    one(8'h06);
    st();
    cmp8(r, 8'h02);
    one(8'h04);
    st();
    cmp8(r, 8'h00);
    cmd(8'h20, 3'h4, 3'h0, 1'b0, 24'h012345, 8'h00);
    chk_none();
    er(8'h20, 24'h012345);
    chk_op(SFQ_OP_SECT, 18'h12000, 8'hff);
    er(8'h52, 24'h01abcd);
    chk_op(SFQ_OP_BLK, 18'h18000, 8'hff);
    one(8'h06);
    one(8'h60);
    chk_op(SFQ_OP_CHIP, 18'hx, 8'hff);
    one(8'h06);
    cmd(8'haf, 3'h5, 3'h0, 1'b0, 24'h000010, 8'h3c);
    chk_op(SFQ_OP_PROG, 18'h00010, 8'h3c);
    st();
    cmp8(r, 8'h42);
    cmd(8'haf, 3'h2, 3'h0, 1'b1, 24'h0, 8'hc3);
    chk_op(SFQ_OP_PROG, 18'h00011, 8'hc3);
    one(8'h04);
    st();
    cmp8(r, 8'h00);
    status_write_cmd(8'h0c);
    st();
    cmp8(r, 8'h0c);
    one(8'h06);
    one(8'h60);
    chk_none();
    er(8'h20, 24'h000000);
    chk_none();
    cmd(8'haf, 3'h5, 3'h0, 1'b0, 24'h000100, 8'h01);
    chk_none();
    one(8'h04);
    cmd(8'h01, 3'h2, 3'h0, 1'b1, 24'h0, 8'h00);
    st();
    cmp8(r, 8'h0c);
    one(8'h50);
    one(8'h06);
    cmd(8'h01, 3'h2, 3'h0, 1'b1, 24'h0, 8'h00);
    st();
    cmp8(r, 8'h0e);
    one(8'h04);
    status_write_cmd(8'h04);
    one(8'h06);
    cmd(8'haf, 3'h5, 3'h0, 1'b0, 24'h02ffff, 8'h5a);
    chk_op(SFQ_OP_PROG, 18'h2ffff, 8'h5a);
    st();
    cmp8(r, 8'h04);
    er(8'h52, 24'h030000);
    chk_none();
    one(8'h04);
    wb(3'h4, 1'b1, 32'h0);
    status_write_cmd(8'h84);
    st();
    cmp8(r, 8'h84);
    status_write_cmd(8'h00);
    st();
    cmp8(r, 8'h84);
    wb(3'h4, 1'b1, 32'h1);
    status_write_cmd(8'h00);
    st();
    cmp8(r, 8'h00);
    cmd(8'h90, 3'h4, 3'h2, 1'b0, 24'h000000, 8'h00);
    cmp8(r, 8'ha5);
    cmd(8'hab, 3'h4, 3'h1, 1'b0, 24'h000001, 8'h00);
    cmp8(r, 8'ha5);
    cmd(8'hab, 3'h4, 3'h2, 1'b0, 24'h000001, 8'h00);
    cmp8(r, 8'h5a);
    cmd(8'h90, 3'h4, 3'h1, 1'b0, 24'h000000, 8'h00);
    cmp8(r, 8'h5a);
    one(8'h06);
    one(8'hff);
    st();
    cmp8(r, 8'h02);
    one(8'h04);
    busy <= 1'b1;
    cmd(8'h05, 3'h1, 3'h3, 1'b1, 24'h0, 8'h00);
    cmp8(r, 8'h01);
    cmp8(status, 8'h01);
    busy <= 1'b0;
    print_verdict;
  end
endmodule
`default_nettype wire
